// ---- dv/testbench.sv ----
// Self-checking bench for the timer: AXI4-Lite tasks and counting model
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] RUN = 16'h8000;
  localparam logic [15:0] HLT = 16'h2000;
  localparam logic [15:0] GAT = 16'h0040;
  localparam logic [15:0] SYN = 16'h0004;
  localparam logic [15:0] SRC = 16'h0002;
  logic        i_clk, i_resetn, i_ce, i_idle, i_ext_clk, i_gate;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [3:0]  i_awaddr, i_araddr, i_wstrb;
  logic [31:0] i_wdata;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_match;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          div[4] = '{1, 8, 64, 256};
  logic [15:0] g;
  logic [1:0]  bresp_seen;
  logic [1:0]  rresp_seen;
  int          t1;
  int          expect_cnt;

  tmr_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_idle(i_idle), .i_ext_clk(i_ext_clk), .i_gate(i_gate),
    .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_rready(i_rready), .o_period_match_r(o_match));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) cyc <= cyc + 1;

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input int lo, input int hi,
                     input logic [15:0] v);
    tests_run++;
    if ($isunknown(v) || int'(v) < lo || int'(v) > hi) begin
      num_errors++;
      $display("Error %s expected %0d..%0d seen %h", nm, lo, hi, v);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= {16'h0000, d};
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1 && n < 50);
    bresp_seen = o_bresp;
    i_bready <= 1'b0;
    if (o_bvalid !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1 && n < 50);
    d = o_rdata[15:0];
    rresp_seen = o_rresp;
    i_rready <= 1'b0;
    if (o_rvalid !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask : rd

  // Runs the timer for w cycles plus k pin pulses; n is the model divisor,
  // 0 for a held count, -1 for counting pin pulses
  task automatic run(input string nm, input logic [15:0] c, input int w,
                     input int n, input int k, input int tol);
    int t0;
    int ex;
    logic [15:0] h;
    wr(tmr_pkg::ADDR_COUNT, 16'h0000);
    wr(tmr_pkg::ADDR_CONTROL, c);
    t0 = cyc;
    for (int i = 0; i < k; i++) begin
      @(posedge i_clk);
      i_ext_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_ext_clk <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (w) @(posedge i_clk);
    wr(tmr_pkg::ADDR_CONTROL, c & ~RUN);
    ex = (n > 0) ? (cyc - t0) / n : ((n == 0) ? 0 : k);
    rd(tmr_pkg::ADDR_COUNT, h);
    chk(nm, ex - tol, ex + tol, h);
    repeat (20) @(posedge i_clk);
    rd(tmr_pkg::ADDR_COUNT, g);
    chk("held count", h, h, g);
    $display("test %s done", nm);
  endtask : run

  initial begin
    void'($urandom(32'h72c6));
    {i_resetn, i_idle, i_ext_clk, i_gate} = 4'h0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr} = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'hf;
    i_ce = 1'b1;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(tmr_pkg::ADDR_CONTROL, g);
    chk("control reset", 0, 0, g);
    rd(tmr_pkg::ADDR_PERIOD, g);
    chk("period reset", 16'hffff, 16'hffff, g);
    wr(tmr_pkg::ADDR_CONTROL, 16'hffff);
    rd(tmr_pkg::ADDR_CONTROL, g);
    chk("control bits", 16'ha076, 16'ha076, g);
    wr(tmr_pkg::ADDR_CONTROL, 16'h0000);
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      run("prescale", 16'(p << 4) | RUN, 600, div[p], 0, 2);
    end
    run("stopped", 16'h0000, 0, 0, 0, 0);
    @(posedge i_clk);
    i_idle <= 1'b1;
    run("idle halt", HLT | RUN, 100, 0, 0, 0);
    run("idle run", RUN, 100, 1, 0, 2);
    @(posedge i_clk);
    i_idle <= 1'b0;
    run("gate low", GAT | RUN, 100, 0, 0, 0);
    @(posedge i_clk);
    i_gate <= 1'b1;
    run("gate high", GAT | RUN, 100, 1, 0, 2);
    @(posedge i_clk);
    i_gate <= 1'b0;
    // Gate fall in gated mode raises the match flag
    repeat (5) @(posedge i_clk);
    rd(tmr_pkg::ADDR_STATUS, g);
    chk("gate fall flag", 1, 1, g);
    chk("match pin", 1, 1, {15'h0000, o_match});
    wr(tmr_pkg::ADDR_STATUS, 16'h0001);
    chk("status bresp", 2, 2, {14'h0000, bresp_seen});
    rd(tmr_pkg::ADDR_STATUS, g);
    chk("flag cleared", 0, 0, g);
    chk("cleared pin", 0, 0, {15'h0000, o_match});
    rd(4'h2, g);
    chk("unmapped rresp", 2, 2, {14'h0000, rresp_seen});
    chk("unmapped rdata", 0, 0, g);
    $display("test status done");
    // Model: 1:1 count wraps to zero after reaching the period
    wr(tmr_pkg::ADDR_PERIOD, 16'h0009);
    chk("period bresp", 0, 0, {14'h0000, bresp_seen});
    wr(tmr_pkg::ADDR_COUNT, 16'h0000);
    wr(tmr_pkg::ADDR_CONTROL, RUN);
    t1 = cyc;
    repeat (40 + $urandom % 32) @(posedge i_clk);
    wr(tmr_pkg::ADDR_CONTROL, 16'h0000);
    expect_cnt = (cyc - t1) % 10;
    rd(tmr_pkg::ADDR_COUNT, g);
    chk("wrap count", expect_cnt, expect_cnt, g);
    rd(tmr_pkg::ADDR_STATUS, g);
    chk("wrap match", 1, 1, g);
    wr(tmr_pkg::ADDR_PERIOD, 16'hffff);
    $display("test wrap done");
    // Model: cycles with clock enable low add nothing to the count
    wr(tmr_pkg::ADDR_COUNT, 16'h0000);
    wr(tmr_pkg::ADDR_CONTROL, RUN);
    t1 = cyc;
    @(posedge i_clk);
    i_ce <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_ce <= 1'b1;
    wr(tmr_pkg::ADDR_CONTROL, 16'h0000);
    expect_cnt = cyc - t1 - 20;
    rd(tmr_pkg::ADDR_COUNT, g);
    chk("ce freeze", expect_cnt, expect_cnt, g);
    $display("test clock enable done");
    run("ext async", SRC | GAT | RUN, 8, -1, 5 + $urandom % 16, 0);
    run("ext sync", SRC | SYN | RUN, 8, -1, 5 + $urandom % 16, 0);
    final_report();
  end
endmodule : testbench

// ---- verilog/tmr_pkg.sv ----
// Package: register map, control field layout and types for the timer
package tmr_pkg;
  localparam logic [3:0]  ADDR_CONTROL  = 4'h0;
  localparam logic [3:0]  ADDR_COUNT    = 4'h4;
  localparam logic [3:0]  ADDR_PERIOD   = 4'h8;
  localparam logic [3:0]  ADDR_STATUS   = 4'hc;
  localparam int          BIT_RUN       = 15;
  localparam int          BIT_HALT_IDLE = 13;
  localparam int          BIT_GATE      = 6;
  localparam int          BIT_PS_LO     = 4;
  localparam int          BIT_SYNC      = 2;
  localparam int          BIT_SRC       = 1;
  localparam logic [15:0] CONTROL_MASK  = 16'ha076;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] PERIOD_RESET  = 16'hffff;
  localparam logic [7:0]  PS_DIV1       = 8'h00;
  localparam logic [7:0]  PS_DIV8       = 8'h07;
  localparam logic [7:0]  PS_DIV64      = 8'h3f;
  localparam logic [7:0]  PS_DIV256     = 8'hff;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef struct packed {
    logic       run;
    logic       halt_idle;
    logic       gate;
    logic [1:0] prescale;
    logic       sync;
    logic       src;
  } ctrl_t;

  function automatic ctrl_t unpack_ctrl(input logic [15:0] v);
    unpack_ctrl.run       = v[BIT_RUN];
    unpack_ctrl.halt_idle = v[BIT_HALT_IDLE];
    unpack_ctrl.gate      = v[BIT_GATE];
    unpack_ctrl.prescale  = v[BIT_PS_LO+1:BIT_PS_LO];
    unpack_ctrl.sync      = v[BIT_SYNC];
    unpack_ctrl.src       = v[BIT_SRC];
  endfunction : unpack_ctrl

  function automatic logic [7:0] ps_limit(input logic [1:0] code);
    case (code)
      2'b11:   ps_limit = PS_DIV256;
      2'b10:   ps_limit = PS_DIV64;
      2'b01:   ps_limit = PS_DIV8;
      default: ps_limit = PS_DIV1;
    endcase
  endfunction : ps_limit
endpackage : tmr_pkg

// ---- verilog/tmr_prescaler.sv ----
// Prescaler that passes one tick in 1, 8, 64 or 256 input ticks
`timescale 1ns/1ps
module tmr_prescaler (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  input  wire logic       i_clr,
  input  wire logic       i_tick,
  input  wire logic [1:0] i_sel,
  output logic            o_tick
);
  logic [7:0] cnt_r;
  logic [7:0] lim;

  assign lim = tmr_pkg::ps_limit(i_sel);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 8'h00;
    end else if (i_ce) begin
      if (i_clr) begin
        cnt_r <= 8'h00;
      end else if (i_tick) begin
        cnt_r <= (cnt_r >= lim) ? 8'h00 : 8'(cnt_r + 8'h01);
      end
    end
  end

  assign o_tick = i_tick && (cnt_r >= lim);

  a_ps_divide: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_tick && !i_clr && i_sel == 2'b01 && cnt_r != 8'h07
    |-> !o_tick)
    else $error("prescaler 1:8 ticked early");
endmodule : tmr_prescaler

// ---- verilog/tmr_top.sv ----
// Top: 16-bit timer with one control register on an AXI4-Lite slave
// Function
// - Halt-in-idle bit stops counting in Idle
// - Internal clock: gate bit selects gated accumulation
// - Prescale field divides 1, 8, 64, 256
// - Sync bit synchronises external clock input
// - Source bit picks pin rising edge or internal
// - Unimplemented control bits read as zero
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tmr_top (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_idle,
  input  wire logic        i_ext_clk,
  input  wire logic        i_gate,
  input  wire logic        i_awvalid,
  input  wire logic [3:0]  i_awaddr,
  output logic             o_awready,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_wready,
  output logic             o_bvalid,
  output logic [1:0]       o_bresp,
  input  wire logic        i_bready,
  input  wire logic        i_arvalid,
  input  wire logic [3:0]  i_araddr,
  output logic             o_arready,
  output logic             o_rvalid,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_rready,
  output logic             o_period_match_r
);
  logic [15:0]   control_r;
  logic [15:0]   count_r;
  logic [15:0]   period_r;
  tmr_pkg::ctrl_t ctl;
  logic [2:0]    ext_sync_r;
  logic [1:0]    ext_raw_r;
  logic [1:0]    gate_sync_r;
  logic [1:0]    idle_sync_r;
  logic          gate_prev_r;
  logic          ext_edge;
  logic          raw_edge;
  logic          gate_fall;
  logic          in_tick;
  logic          enabled;
  logic          ps_tick;
  logic          count_tick;
  logic          period_hit;
  logic          aw_held_r;
  logic          w_held_r;
  logic [3:0]    aw_addr_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;
  logic          do_write;
  logic          wr_count;
  logic          wr_ctrl_any;
  logic [15:0]   wmask;

  assign ctl = tmr_pkg::unpack_ctrl(control_r);

  // Two-stage synchronisers; third stage of ext only feeds edge detection
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_sync_r  <= 3'b000;
      gate_sync_r <= 2'b00;
      idle_sync_r <= 2'b00;
      gate_prev_r <= 1'b0;
    end else if (i_ce) begin
      ext_sync_r  <= {ext_sync_r[1:0], i_ext_clk};
      gate_sync_r <= {gate_sync_r[0], i_gate};
      idle_sync_r <= {idle_sync_r[0], i_idle};
      gate_prev_r <= gate_sync_r[1];
    end
  end

  // Unsynchronised path: two-flop edge catch, same latency as the synchronised path
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_raw_r <= 2'b00;
    end else if (i_ce) begin
      ext_raw_r <= {ext_raw_r[0], i_ext_clk};
    end
  end

  assign ext_edge = ext_sync_r[1] && !ext_sync_r[2];
  assign raw_edge = ext_raw_r[1] && !ext_sync_r[2];
  assign gate_fall = gate_prev_r && !gate_sync_r[1];

  always_comb begin
    if (ctl.src) begin
      in_tick = ctl.sync ? ext_edge : raw_edge;
    end else if (ctl.gate) begin
      in_tick = gate_sync_r[1];
    end else begin
      in_tick = 1'b1;
    end
  end

  assign enabled = ctl.run && !(ctl.halt_idle && idle_sync_r[1]);

  tmr_prescaler u_ps (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_clr    (wr_ctrl_any || wr_count),
    .i_tick   (in_tick && enabled),
    .i_sel    (ctl.prescale),
    .o_tick   (ps_tick)
  );

  assign count_tick = ps_tick && enabled;
  assign period_hit = count_tick && (count_r == period_r);

  // Write channel capture; address and data accepted in either order
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= tmr_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held_r  <= 1'b1;
        w_data_r  <= i_wdata;
        w_strb_r  <= i_wstrb;
        o_wready  <= 1'b0;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= (aw_addr_r == tmr_pkg::ADDR_STATUS)
                     ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  assign do_write = aw_held_r && w_held_r && !o_bvalid;
  assign wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wr_ctrl_any = i_ce && do_write && aw_addr_r == tmr_pkg::ADDR_CONTROL;
  assign wr_count = i_ce && do_write && aw_addr_r == tmr_pkg::ADDR_COUNT;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      control_r <= tmr_pkg::CONTROL_RESET;
    end else if (wr_ctrl_any) begin
      control_r <= ((control_r & ~wmask) | (w_data_r[15:0] & wmask))
                   & tmr_pkg::CONTROL_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      period_r <= tmr_pkg::PERIOD_RESET;
    end else if (i_ce && do_write && aw_addr_r == tmr_pkg::ADDR_PERIOD) begin
      period_r <= (period_r & ~wmask) | (w_data_r[15:0] & wmask);
    end
  end

  // Counter: software write wins; otherwise wrap at period
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_r <= tmr_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_r <= (count_r & ~wmask) | (w_data_r[15:0] & wmask);
    end else if (i_ce && period_hit) begin
      count_r <= 16'h0000;
    end else if (i_ce && count_tick) begin
      count_r <= 16'(count_r + 16'h0001);
    end
  end

  // Match flag: gate fall in gated mode also flags; set wins over clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_period_match_r <= 1'b0;
    end else if (i_ce) begin
      if (period_hit || (ctl.gate && !ctl.src && gate_fall)) begin
        o_period_match_r <= 1'b1;
      end else if (do_write && aw_addr_r == tmr_pkg::ADDR_STATUS
                   && w_strb_r[0] && w_data_r[0]) begin
        o_period_match_r <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= tmr_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rresp   <= tmr_pkg::RESP_OKAY;
        case (i_araddr)
          tmr_pkg::ADDR_CONTROL: o_rdata <= {16'h0000,
                                   control_r & tmr_pkg::CONTROL_MASK};
          tmr_pkg::ADDR_COUNT:   o_rdata <= {16'h0000, count_r};
          tmr_pkg::ADDR_PERIOD:  o_rdata <= {16'h0000, period_r};
          tmr_pkg::ADDR_STATUS:  o_rdata <= {31'h0000_0000, o_period_match_r};
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= tmr_pkg::RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  a_halt_keeps: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && !ctl.run && !wr_count |=> $stable(count_r))
    else $error("count moved while stopped");
  a_idle_stops: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && ctl.halt_idle && idle_sync_r[1] && !wr_count
    |=> $stable(count_r))
    else $error("count moved in idle with halt set");
  a_idle_runs: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && ctl.run && !ctl.halt_idle && idle_sync_r[1] && !ctl.src
    && !ctl.gate && ctl.prescale == 2'b00 && !period_hit && !wr_count
    |=> count_r == 16'($past(count_r) + 16'h0001))
    else $error("count stopped in idle with halt clear");
  a_gate_low_hold: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && ctl.gate && !ctl.src && !gate_sync_r[1] && !wr_count
    |=> $stable(count_r))
    else $error("gated count moved with gate low");
  a_gate_high_count: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && ctl.run && !ctl.halt_idle && ctl.gate && !ctl.src
    && gate_sync_r[1] && ctl.prescale == 2'b00 && !period_hit && !wr_count
    |=> count_r == 16'($past(count_r) + 16'h0001))
    else $error("gated count missed a cycle with gate high");
  a_free_run: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && ctl.run && !ctl.halt_idle && !ctl.src && !ctl.gate
    && ctl.prescale == 2'b00 && !period_hit && !wr_count
    |=> count_r == 16'($past(count_r) + 16'h0001))
    else $error("1:1 internal count did not step");
  a_sync_edge: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ctl.src && ctl.sync |-> in_tick == ext_edge)
    else $error("sync path mismatch");
  a_ext_no_edge: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && ctl.src && ctl.sync && !ext_edge && !wr_count
    |=> $stable(count_r))
    else $error("external mode counted without edge");
  a_ext_edge_count: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && ctl.run && !ctl.halt_idle && ctl.src && ext_edge
    && ctl.prescale == 2'b00 && !period_hit && !wr_count
    |=> count_r == 16'($past(count_r) + 16'h0001))
    else $error("external edge not counted");
  a_wrap_zero: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && period_hit && !wr_count |=> count_r == 16'h0000)
    else $error("count did not wrap at period");
  a_match_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && period_hit |=> o_period_match_r)
    else $error("match flag not set on wrap");
  a_ce_freeze: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !i_ce |=> $stable(count_r) && $stable(control_r)
    && $stable(o_period_match_r) && $stable(o_bvalid))
    else $error("state moved with clock enable low");
  a_ctrl_zero: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (control_r & ~tmr_pkg::CONTROL_MASK) == 16'h0000)
    else $error("unimplemented control bit set");
  a_read_zero: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_arvalid && o_arready && i_araddr == tmr_pkg::ADDR_CONTROL
    |=> (o_rdata[15:0] & ~tmr_pkg::CONTROL_MASK) == 16'h0000)
    else $error("control read showed unimplemented bits");

  c_ext_count: cover property (@(posedge i_clk) disable iff (!i_resetn)
    ctl.src && count_tick);
  c_gated: cover property (@(posedge i_clk) disable iff (!i_resetn)
    ctl.gate && !ctl.src && gate_fall);
  c_div256: cover property (@(posedge i_clk) disable iff (!i_resetn)
    ctl.prescale == 2'b11 && count_tick);
  c_wrap: cover property (@(posedge i_clk) disable iff (!i_resetn)
    period_hit);
  c_ce_frozen: cover property (@(posedge i_clk) disable iff (!i_resetn)
    !i_ce && ctl.run);
endmodule : tmr_top
